// File: logic/bdp_pkg.sv
// shared constants and types for the burst ddr sram port
package bdp_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 18;
    localparam int LANE_W = 9;
    localparam int BEATS = 4;
    localparam int BURST_W = DATA_W * BEATS;
    localparam int BEN_W = 2 * BEATS;
    // queued request layout: write flag, address, four beats, byte enables
    localparam int REQ_BEN_LSB = 0;
    localparam int REQ_DATA_LSB = REQ_BEN_LSB + BEN_W;
    localparam int REQ_ADDR_LSB = REQ_DATA_LSB + BURST_W;
    localparam int REQ_WR_BIT = REQ_ADDR_LSB + ADDR_W;
    localparam int REQ_W = REQ_WR_BIT + 1;
    localparam int FIFO_DEPTH = 4;
    // link edge positions counted from the load edge (edge 0)
    localparam int WR_FIRST = 2;
    localparam int RD_FIRST = 3;
    localparam int PIPE_LEN = 6;
    localparam int GAP_STAGE = 2;
    localparam logic [3:0] HOST_END_EDGE = 4'h8;
    // timing
    localparam int CLK_NS = 100;
    localparam int LINK_DIV = 2;
    localparam int LINK_NS = CLK_NS * LINK_DIV;
    localparam int LOCK_US = 20;
    localparam int LOCK_NS = LOCK_US * 1000;
    localparam int CNT_W = 9;
    localparam logic [CNT_W-1:0] DEV_LOCK_CYC = CNT_W'((LOCK_NS + LINK_NS - 1) / LINK_NS);
    localparam int HOST_LOCK_CYC = LOCK_NS / CLK_NS + 1;
    localparam int HOST_MARGIN_CYC = 16;
    localparam logic [CNT_W-1:0] HOST_WAIT_CYC = CNT_W'(HOST_LOCK_CYC + HOST_MARGIN_CYC);
    typedef logic [ADDR_W-1:0] bdp_addr_t;
    typedef logic [DATA_W-1:0] bdp_data_t;
    typedef enum logic [1:0] {BDP_WAIT, BDP_IDLE, BDP_BURST} bdp_host_st_t;
endpackage

// File: logic/bdp_link_if.sv
`timescale 1ns/10ps
// link wires between the memory controller and the burst ddr sram
interface bdp_link_if;
    import bdp_pkg::*;
    logic link_clk;
    logic k_true;
    logic c_true;
    logic c_hold_high;
    logic load_strobe_n;
    logic rnw;
    bdp_addr_t addr;
    logic lower_byte_write_en_n;
    logic upper_byte_write_en_n;
    bdp_data_t hdq_o;
    logic hdq_oe;
    bdp_data_t ddq_o;
    logic ddq_oe;
    modport dev (
        input link_clk,
        input k_true,
        input c_true,
        input c_hold_high,
        input load_strobe_n,
        input rnw,
        input addr,
        input lower_byte_write_en_n,
        input upper_byte_write_en_n,
        input hdq_o,
        output ddq_o,
        output ddq_oe
    );
    modport host (
        output link_clk,
        output k_true,
        output c_true,
        output c_hold_high,
        output load_strobe_n,
        output rnw,
        output addr,
        output lower_byte_write_en_n,
        output upper_byte_write_en_n,
        output hdq_o,
        output hdq_oe,
        input ddq_o,
        input ddq_oe
    );
endinterface

// File: logic/bdp_fifo.sv
`timescale 1ns/10ps
// small valid/ready fifo with registered flags
module bdp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [0:DEPTH-1];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [PW:0] cnt_r;
    logic [PW:0] cnt_nxt;
    logic push;
    logic pop;
    logic not_full_r;
    logic not_empty_r;

    assign push = in_valid && not_full_r;
    assign pop = out_ready && not_empty_r;
    assign in_ready = not_full_r;
    assign out_valid = not_empty_r;
    assign out_data = mem_r[rp_r];
    assign cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);

    // storage, no reset needed
    always_ff @(posedge clock) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    // pointers and flags; flags registered so ready is a flop
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            not_full_r <= 1'b1;
            not_empty_r <= 1'b0;
        end else begin
            if (push) begin
                wp_r <= PW'((32'(wp_r) + 1) % DEPTH);
            end
            if (pop) begin
                rp_r <= PW'((32'(rp_r) + 1) % DEPTH);
            end
            cnt_r <= cnt_nxt;
            not_full_r <= (32'(cnt_nxt) != DEPTH);
            not_empty_r <= (cnt_nxt != '0);
        end
    end
endmodule

// File: logic/bdp_sram_dev.sv
`timescale 1ns/10ps
// burst ddr sram device end, clocked by the link clock
module bdp_sram_dev (
    bdp_link_if.dev lnk,
    input wire logic sys_rst,
    output logic pll_locked
);
    import bdp_pkg::*;

    // reset crossing into the link domain
    logic rst_s1_r;
    logic rst_s2_r;

    // power-up lock emulation
    logic [CNT_W-1:0] lock_cnt_r;
    logic locked_r;

    // command acceptance
    logic accept;

    // per-stage view of loaded bursts
    logic [PIPE_LEN:1] stg_v;
    logic [PIPE_LEN:1] stg_w;
    bdp_addr_t stg_a [1:PIPE_LEN];

    // beat selection
    logic wr_hit;
    bdp_addr_t wr_a;
    logic rd_hit;
    logic rd_odd;
    bdp_addr_t rd_a;
    logic ref_ph;
    logic rd_go;

    // per-beat hits and addresses, one entry per beat of a burst
    logic [BEATS-1:0] wr_beat;
    logic [BEATS-1:0] rd_beat;
    bdp_addr_t wr_beat_a [BEATS];
    bdp_addr_t rd_beat_a [BEATS];

    // command decode at the current link edge
    logic idle_cycle;
    logic burst_busy;

    // per-lane write strobes of the current beat
    logic [1:0] lane_en_n;
    logic [1:0] lane_we;

    // storage and output flops
    bdp_data_t mem [0:(1<<ADDR_W)-1];
    bdp_data_t dq_o_r;
    logic dq_oe_r;

    // next word of a burst: only the two low bits advance
    function automatic bdp_addr_t burst_addr(input bdp_addr_t start, input logic [1:0] beat);
        logic [1:0] low;
        low = start[1:0] + beat;
        burst_addr = {start[ADDR_W-1:2], low};
    endfunction

    // sys_rst comes from the controller clock; the first flop feeds only the second
    always_ff @(posedge lnk.link_clk) begin
        rst_s1_r <= sys_rst;
        rst_s2_r <= rst_s1_r;
    end

    // lock counter; a stopped link clock simply freezes it
    // commands are ignored until it ends, not only kept off the bus
    always_ff @(posedge lnk.link_clk) begin
        if (rst_s2_r) begin
            lock_cnt_r <= '0;
            locked_r <= 1'b0;
        end else if (!locked_r) begin
            lock_cnt_r <= lock_cnt_r + 1'b1;
            locked_r <= (lock_cnt_r == DEV_LOCK_CYC - 1'b1);
        end
    end

    assign pll_locked = locked_r;

    // nothing is loaded on an idle_cycle: deselected, a K# rise, or not yet locked
    assign idle_cycle = lnk.load_strobe_n || !lnk.k_true || !locked_r;

    // the earlier burst still sits in stage two at the next true-clock rise,
    // so a command there is dropped rather than cutting that burst short
    assign burst_busy = stg_v[GAP_STAGE];

    // address and direction are looked at only when both allow a load
    assign accept = !idle_cycle && !burst_busy;

    // stage one: address and direction taken only for an accepted load
    always_ff @(posedge lnk.link_clk) begin
        if (rst_s2_r) begin
            stg_v[1] <= 1'b0;
        end else begin
            stg_v[1] <= accept;
        end
    end

    always_ff @(posedge lnk.link_clk) begin
        if (accept) begin
            stg_w[1] <= ~lnk.rnw;
            stg_a[1] <= lnk.addr;
        end
    end

    // later stages just age the burst by one link edge each
    for (genvar s = 2; s <= PIPE_LEN; s++) begin : g_stage
        always_ff @(posedge lnk.link_clk) begin
            if (rst_s2_r) begin
                stg_v[s] <= 1'b0;
            end else begin
                stg_v[s] <= stg_v[s-1];
            end
            stg_w[s] <= stg_w[s-1];
            stg_a[s] <= stg_a[s-1];
        end
    end

    // each beat owns a fixed stage, so the match is a plain per-beat decode
    for (genvar b = 0; b < BEATS; b++) begin : g_beat
        assign wr_beat[b] = stg_v[WR_FIRST + b] && stg_w[WR_FIRST + b];
        assign rd_beat[b] = stg_v[RD_FIRST + b] && !stg_w[RD_FIRST + b];
        assign wr_beat_a[b] = burst_addr(stg_a[WR_FIRST + b], 2'(b));
        assign rd_beat_a[b] = burst_addr(stg_a[RD_FIRST + b], 2'(b));
    end

    // write beats fall on edges two to five after the load: K, K#, K, K#
    // loads are at least four edges apart, so at most one beat matches
    always_comb begin
        wr_hit = 1'b0;
        wr_a = '0;
        for (int j = 0; j < BEATS; j++) begin
            if (wr_beat[j]) begin
                wr_hit = 1'b1;
                wr_a = wr_beat_a[j];
            end
        end
    end

    // read beats fall on edges three to six: C#, C, C#, C
    always_comb begin
        rd_hit = 1'b0;
        rd_odd = 1'b0;
        rd_a = '0;
        for (int j = 0; j < BEATS; j++) begin
            if (rd_beat[j]) begin
                rd_hit = 1'b1;
                rd_odd = ((j % 2) == 1);
                rd_a = rd_beat_a[j];
            end
        end
    end

    // output reference: the output pair, or the input pair when it is parked high
    assign ref_ph = lnk.c_hold_high ? lnk.k_true : lnk.c_true;

    // per-lane strobes; enables are read at the same edge as the data they qualify
    assign lane_en_n = {lnk.upper_byte_write_en_n, lnk.lower_byte_write_en_n};
    for (genvar l = 0; l < 2; l++) begin : g_lane
        assign lane_we[l] = wr_hit && !lane_en_n[l];
    end

    // data taken on every link edge, so beats on both input phases land;
    // a beat with both enables high leaves the word as it was
    always_ff @(posedge lnk.link_clk) begin
        for (int l = 0; l < 2; l++) begin
            if (lane_we[l]) begin
                mem[wr_a][l*LANE_W +: LANE_W] <= lnk.hdq_o[l*LANE_W +: LANE_W];
            end
        end
    end

    // a beat whose reference edge is of the wrong phase is not driven,
    // which keeps the bus quiet if the output pair is misaligned
    assign rd_go = rd_hit && (ref_ph == rd_odd);

    // read launch; outputs stay off until the lock count has run out
    always_ff @(posedge lnk.link_clk) begin
        if (rst_s2_r || !locked_r) begin
            dq_oe_r <= 1'b0;
            dq_o_r <= '0;
        end else if (rd_go) begin
            dq_oe_r <= 1'b1;
            dq_o_r <= mem[rd_a];
        end else begin
            dq_oe_r <= 1'b0;
        end
    end

    // nothing here runs without link edges, so a stopped clock keeps every flop
    assign lnk.ddq_o = dq_o_r;
    assign lnk.ddq_oe = dq_oe_r;
endmodule

// File: logic/bdp_ctrl_host.sv
`timescale 1ns/10ps
// memory controller end: queues bursts and drives the link
module bdp_ctrl_host (
    bdp_link_if.host lnk,
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [bdp_pkg::ADDR_W-1:0] req_addr,
    input wire logic [bdp_pkg::BURST_W-1:0] req_data,
    input wire logic [bdp_pkg::BEN_W-1:0] req_ben_n,
    output logic resp_valid,
    output logic [bdp_pkg::BURST_W-1:0] resp_data,
    output logic link_ready
);
    import bdp_pkg::*;

    logic f_valid;
    logic f_ready;
    logic [REQ_W-1:0] f_data;
    logic [REQ_W-1:0] cur_r;
    bdp_host_st_t state_r;
    logic [CNT_W-1:0] wait_cnt_r;
    logic [3:0] ecnt_r;
    logic [3:0] nxt;
    logic [1:0] bidx;
    logic prep;
    logic nk;
    logic link_clk_r;
    logic rst_d_r;
    logic link_ready_r;
    logic k_r;
    logic ld_n_r;
    logic rnw_r;
    bdp_addr_t addr_r;
    logic lben_n_r;
    logic uben_n_r;
    bdp_data_t dq_o_r;
    logic dq_oe_r;
    bdp_data_t dq_s1_r;
    bdp_data_t dq_s2_r;
    logic oe_s1_r;
    logic oe_s2_r;
    logic [1:0] bcnt_r;
    logic [BURST_W-1:0] rbuf_r;
    logic resp_valid_r;
    logic [BURST_W-1:0] resp_data_r;

    bdp_fifo #(
        .WIDTH(REQ_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .sys_rst(sys_rst),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data({req_write, req_addr, req_data, req_ben_n}),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    // link edges come on the clocks where link_clk_r rises; outputs change a
    // clock earlier, as it falls, giving one full clock of setup
    assign prep = link_clk_r;
    assign nk = ~k_r;
    assign nxt = ecnt_r + 4'h1;
    assign bidx = 2'(nxt - 4'h2);
    // the queue stalls until the link is locked and idle
    assign f_ready = prep && nk && (state_r == BDP_IDLE) && f_valid;

    // reset entry is the clock where sys_rst is high and was low before
    always_ff @(posedge clock) begin
        rst_d_r <= sys_rst;
    end

    // link clock divider: cleared as reset begins, then left running so the
    // sram end, which only sees reset on link edges, is reset as well; the
    // link runs far below the pll floor, and that end still waits out its lock count before taking commands
    always_ff @(posedge clock) begin
        if (!sys_rst || rst_d_r) begin
            link_clk_r <= ~link_clk_r;
        end else begin
            link_clk_r <= 1'b0;
        end
    end

    // k and c alternate on every link edge without pause
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            k_r <= 1'b0;
        end else if (prep) begin
            k_r <= nk;
        end
    end

    // sequencing: power-up wait, then one burst at a time
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_r <= BDP_WAIT;
            wait_cnt_r <= '0;
            ecnt_r <= '0;
            link_ready_r <= 1'b0;
        end else begin
            unique case (state_r)
                BDP_WAIT: begin
                    wait_cnt_r <= wait_cnt_r + 1'b1;
                    if (wait_cnt_r == HOST_WAIT_CYC - 1'b1) begin
                        state_r <= BDP_IDLE;
                        link_ready_r <= 1'b1;
                    end
                end
                BDP_IDLE: begin
                    if (f_ready) begin
                        ecnt_r <= '0;
                        state_r <= BDP_BURST;
                    end
                end
                BDP_BURST: begin
                    if (prep) begin
                        ecnt_r <= nxt;
                        if (nxt == HOST_END_EDGE) begin
                            state_r <= BDP_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (f_ready) begin
            cur_r <= f_data;
        end
    end

    // command and write data for the coming edge
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ld_n_r <= 1'b1;
            rnw_r <= 1'b1;
            addr_r <= '0;
            lben_n_r <= 1'b1;
            uben_n_r <= 1'b1;
            dq_o_r <= '0;
            dq_oe_r <= 1'b0;
        end else if (prep) begin
            ld_n_r <= ~f_ready;
            lben_n_r <= 1'b1;
            uben_n_r <= 1'b1;
            dq_oe_r <= 1'b0;
            if (f_ready) begin
                rnw_r <= ~f_data[REQ_WR_BIT];
                addr_r <= f_data[REQ_ADDR_LSB +: ADDR_W];
            end else if (state_r == BDP_BURST && cur_r[REQ_WR_BIT]
                         && nxt >= 4'(WR_FIRST) && nxt < 4'(WR_FIRST + BEATS)) begin
                dq_oe_r <= 1'b1;
                dq_o_r <= cur_r[REQ_DATA_LSB + 32'(bidx) * DATA_W +: DATA_W];
                lben_n_r <= cur_r[REQ_BEN_LSB + 2 * 32'(bidx)];
                uben_n_r <= cur_r[REQ_BEN_LSB + 2 * 32'(bidx) + 1];
            end
        end
    end

    // returned data crosses two flops; sampling on the rising phase keeps one
    // stable sample per beat because each beat lasts two clocks
    always_ff @(posedge clock) begin
        dq_s1_r <= lnk.ddq_o;
        dq_s2_r <= dq_s1_r;
        oe_s1_r <= lnk.ddq_oe;
        oe_s2_r <= oe_s1_r;
    end

    // gather four beats, first beat in the low word
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bcnt_r <= '0;
            resp_valid_r <= 1'b0;
            resp_data_r <= '0;
            rbuf_r <= '0;
        end else begin
            resp_valid_r <= 1'b0;
            if (link_clk_r && oe_s2_r) begin
                rbuf_r <= {dq_s2_r, rbuf_r[BURST_W-1:DATA_W]};
                bcnt_r <= bcnt_r + 1'b1;
                if (bcnt_r == 2'h3) begin
                    resp_valid_r <= 1'b1;
                    resp_data_r <= {dq_s2_r, rbuf_r[BURST_W-1:DATA_W]};
                end
            end
        end
    end

    assign lnk.link_clk = link_clk_r;
    assign lnk.k_true = k_r;
    assign lnk.c_true = k_r;
    assign lnk.c_hold_high = 1'b1;
    assign lnk.load_strobe_n = ld_n_r;
    assign lnk.rnw = rnw_r;
    assign lnk.addr = addr_r;
    assign lnk.lower_byte_write_en_n = lben_n_r;
    assign lnk.upper_byte_write_en_n = uben_n_r;
    assign lnk.hdq_o = dq_o_r;
    assign lnk.hdq_oe = dq_oe_r;
    assign resp_valid = resp_valid_r;
    assign resp_data = resp_data_r;
    assign link_ready = link_ready_r;
endmodule

// File: testbench/bdp_link_properties.sv
// link protocol assertions between the controller end and the sram end
`timescale 1ns/10ps
module bdp_link_properties
    import bdp_pkg::*;
(
    input wire logic link_clk,
    input wire logic sys_rst,
    input wire logic k_true,
    input wire logic c_true,
    input wire logic c_hold_high,
    input wire logic load_strobe_n,
    input wire logic rnw,
    input wire logic lower_byte_write_en_n,
    input wire logic upper_byte_write_en_n,
    input wire logic hdq_oe,
    input wire logic ddq_oe
);
    localparam int LOCK_RISES = LOCK_NS / LINK_NS;
    logic seen_load_r;
    logic [7:0] up_cnt_r;
    logic rd_load;
    logic wr_load;
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (sys_rst);
    // decoded load commands
    assign rd_load = !load_strobe_n && rnw;
    assign wr_load = !load_strobe_n && !rnw;
    // async clear, so the helpers start from zero as reset begins
    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            seen_load_r <= 1'b0;
        end else if (!load_strobe_n) begin
            seen_load_r <= 1'b1;
        end
    end
    // saturating count of link rises since reset
    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            up_cnt_r <= 8'h00;
        end else if (up_cnt_r != 8'hff) begin
            up_cnt_r <= up_cnt_r + 8'h01;
        end
    end
    AST_K_TOGGLE: assert property (k_true |=> !k_true)
        else $error("true input phase did not alternate");
    AST_C_FOLLOWS_K: assert property (c_hold_high && c_true == k_true)
        else $error("output pair not parked on the input pair");
    AST_LOAD_ON_K: assert property (!load_strobe_n |-> k_true)
        else $error("load issued on an inverted input rise");
    AST_LOAD_GAP: assert property (!load_strobe_n |=> load_strobe_n [*3])
        else $error("load issued inside a running burst");
    AST_WR_BEATS: assert property (wr_load |-> ##1 !hdq_oe ##1 hdq_oe [*4] ##1 !hdq_oe)
        else $error("write beats misplaced");
    AST_RD_BEATS: assert property (rd_load |=> !ddq_oe [*3] ##1 ddq_oe [*4] ##1 !ddq_oe)
        else $error("read beats misplaced");
    AST_IDLE_HIGHZ: assert property (ddq_oe |-> $past(rd_load, 4) || $past(rd_load, 5) ||
        $past(rd_load, 6) || $past(rd_load, 7))
        else $error("data driven outside a read burst");
    AST_POWERUP_HIGHZ: assert property ((up_cnt_r > 8'h03 && !seen_load_r) |-> !ddq_oe)
        else $error("data driven before any command");
    AST_LOCK_WAIT: assert property (!load_strobe_n |-> up_cnt_r > LOCK_RISES)
        else $error("command issued before lock time");
    AST_BUS_SHARED: assert property (hdq_oe |-> !ddq_oe)
        else $error("both ends drive the data bus");
    // main scenarios
    cover property (wr_load);
    cover property (rd_load);
    cover property (wr_load ##2 (lower_byte_write_en_n != upper_byte_write_en_n));
endmodule

// File: testbench/tb.sv
// self-checking bench: controller end and sram end joined over the link
`timescale 1ns/10ps
module tb;
    import bdp_pkg::*;
    localparam int TIMEOUT_CYC = 3000;
    logic clock = 1'b0;
    logic sys_rst;
    logic req_valid = 1'b0;
    logic req_ready;
    logic req_write = 1'b0;
    bdp_addr_t req_addr = 20'h00000;
    logic [BURST_W-1:0] req_data = '0;
    logic [BEN_W-1:0] req_ben_n = 8'hff;
    logic resp_valid;
    logic [BURST_W-1:0] resp_data;
    logic link_ready;
    logic pll_locked;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    bdp_data_t pat [BEATS] = '{18'h2a5a1, 18'h15a5e, 18'h3c3c3, 18'h00ff7};

    bdp_link_if lnk_if ();
    bdp_sram_dev bdp_sram_dev_inst (.lnk(lnk_if), .sys_rst(sys_rst), .pll_locked(pll_locked));
    bdp_ctrl_host bdp_ctrl_host_inst (.lnk(lnk_if), .clock(clock), .sys_rst(sys_rst),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
        .req_addr(req_addr), .req_data(req_data), .req_ben_n(req_ben_n),
        .resp_valid(resp_valid), .resp_data(resp_data), .link_ready(link_ready));
    bdp_link_properties bdp_link_properties_inst (.link_clk(lnk_if.link_clk),
        .sys_rst(sys_rst), .k_true(lnk_if.k_true), .c_true(lnk_if.c_true),
        .c_hold_high(lnk_if.c_hold_high), .load_strobe_n(lnk_if.load_strobe_n),
        .rnw(lnk_if.rnw), .lower_byte_write_en_n(lnk_if.lower_byte_write_en_n),
        .upper_byte_write_en_n(lnk_if.upper_byte_write_en_n), .hdq_oe(lnk_if.hdq_oe),
        .ddq_oe(lnk_if.ddq_oe));

    // system clock; the link clock is divided down inside the controller
    always #(CLK_NS / 2) clock = ~clock;

    // four beats of the pattern, rotated by a start offset, optionally inverted
    function automatic logic [BURST_W-1:0] burst(input int rot, input logic inv);
        logic [BURST_W-1:0] r;
        for (int i = 0; i < BEATS; i++) begin
            r[i*DATA_W +: DATA_W] = pat[(i + rot) % BEATS] ^ {DATA_W{inv}};
        end
        return r;
    endfunction

    // per-beat lane merge: a low enable takes the new lane
    function automatic logic [BURST_W-1:0] merge(input logic [BURST_W-1:0] o,
        input logic [BURST_W-1:0] n, input logic [BEN_W-1:0] ben_n);
        logic [BURST_W-1:0] r;
        r = o;
        for (int i = 0; i < BEATS; i++) begin
            if (!ben_n[2*i]) r[i*DATA_W +: LANE_W] = n[i*DATA_W +: LANE_W];
            if (!ben_n[2*i+1]) r[i*DATA_W+LANE_W +: LANE_W] = n[i*DATA_W+LANE_W +: LANE_W];
        end
        return r;
    endfunction

    task automatic fail(input string msg);
        error_cnt++;
        $display("CHECK FAILED t=%0t %s", $time, msg);
    endtask

    task automatic chk_data(input logic [BURST_W-1:0] got, input logic [BURST_W-1:0] exp,
        input string msg);
        compares++;
        if (got !== exp) fail($sformatf("%s got %h exp %h", msg, got, exp));
    endtask

    task automatic chk_flag(input logic got, input logic exp, input string msg);
        compares++;
        if (got !== exp) fail($sformatf("%s got %b", msg, got));
    endtask

    // request held from a falling edge until a rise samples ready high
    task automatic push(input logic wr, input bdp_addr_t a, input logic [BURST_W-1:0] d,
        input logic [BEN_W-1:0] b);
        int n;
        n = 0;
        @(negedge clock);
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_data = d;
        req_ben_n = b;
        do begin
            @(posedge clock);
            n++;
        end while (req_ready !== 1'b1 && n < 400);
        if (n >= 400) fail("request never taken");
        @(negedge clock);
        req_valid = 1'b0;
    endtask

    // one read burst, then wait for its response pulse
    task automatic read_chk(input bdp_addr_t a, input logic [BURST_W-1:0] exp, input string msg);
        int n;
        n = 0;
        push(1'b0, a, '0, 8'hff);
        do begin
            @(negedge clock);
            n++;
        end while (resp_valid !== 1'b1 && n < 400);
        if (n >= 400) fail("no read response");
        else chk_data(resp_data, exp, msg);
    endtask

    // four writes queue up while the link still waits for lock
    task automatic test_fill();
        push(1'b1, 20'h00100, burst(0, 1'b0), 8'h00);
        push(1'b1, 20'h00200, burst(0, 1'b1), 8'h00);
        push(1'b1, 20'h00200, burst(0, 1'b0), 8'h36);
        push(1'b1, 20'h00302, burst(0, 1'b0), 8'h00);
        chk_flag(req_ready, 1'b0, "full queue still ready");
        chk_flag(lnk_if.load_strobe_n, 1'b1, "load before lock wait");
        chk_flag(lnk_if.ddq_oe, 1'b0, "data driven at power-up");
    endtask

    // the controller releases the link only after the lock time
    task automatic test_lock();
        int n;
        n = 0;
        while (link_ready !== 1'b1 && n < 400) begin
            @(negedge clock);
            n++;
        end
        chk_flag(link_ready, 1'b1, "link never ready");
        chk_flag(pll_locked, 1'b1, "device not locked");
    endtask

    // one beat per mask code: lower only, upper only, none, both
    task automatic test_mask();
        read_chk(20'h00200, merge(burst(0, 1'b1), burst(0, 1'b0), 8'h36), "byte mask");
    endtask

    // every start offset, and a write that itself started mid-burst
    task automatic test_wrap();
        for (int s = 0; s < BEATS; s++) begin
            read_chk(20'h00100 + 20'(s), burst(s, 1'b0), "wrapped read");
        end
        read_chk(20'h00300, burst(2, 1'b0), "wrapped write");
    endtask

    // idle cycles leave the shared bus undriven
    task automatic test_idle();
        repeat (40) @(negedge clock);
        chk_flag(lnk_if.ddq_oe, 1'b0, "idle bus driven by sram");
        chk_flag(lnk_if.hdq_oe, 1'b0, "idle bus driven by controller");
    endtask

    task automatic final_report();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc == TIMEOUT_CYC) begin
            fail("timeout");
            final_report();
        end
    end

    // rising reset edge after time zero so async helper flops see it
    initial begin
        sys_rst = 1'b0;
        #1 sys_rst = 1'b1;
        repeat (5) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'b0;
        test_fill();
        test_lock();
        test_mask();
        test_wrap();
        test_idle();
        final_report();
    end
endmodule
